// *** pkg/dsr_pkg.sv ***
/*
 * constants and types shared by the decoder status and raw control block.
 * assumes a single 25 MHz clock and an i2c-style host on scl/sda.
 */
package dsr_pkg;
    // register subaddresses
    localparam logic [7:0] ADDR_RAW_GAIN = 8'h18;
    localparam logic [7:0] ADDR_RAW_OFFSET = 8'h19;
    localparam logic [7:0] ADDR_STATUS_FIRST = 8'h1e;
    localparam logic [7:0] ADDR_STATUS_SECOND = 8'h1f;
    localparam logic [7:0] ADDR_AIC_FIVE = 8'h23;
    // bus slave address, value is arbitrary
    localparam logic [6:0] DEV_ADDR = 7'h21;
    // reset values
    localparam logic [7:0] RAW_GAIN_RST = 8'h80;
    localparam logic [7:0] RAW_OFFSET_RST = 8'h80;
    localparam logic [7:0] AIC_FIVE_RST = 8'h00;
    // writable bits of the analog input control register
    localparam logic [7:0] AIC_FIVE_WR_MASK = 8'hf7;
    // raw datapath scaling
    localparam int RAW_GAIN_SHIFT = 7;
    localparam logic [10:0] RAW_OFFSET_BIAS = 11'h080;
    localparam logic [10:0] RAW_MAX = 11'h0ff;
    // first status byte fields
    localparam int ST1_HORIZ_UNLOCK = 6;
    localparam int ST1_SLOW_TC = 5;
    localparam int ST1_GAIN_TOP = 4;
    localparam int ST1_GAIN_BOTTOM = 3;
    localparam int ST1_WHITE_PEAK = 2;
    localparam int ST1_STD_LSB = 0;
    // second status byte fields
    localparam int ST2_INTERLACE = 7;
    localparam int ST2_HV_UNLOCK = 6;
    localparam int ST2_FIELD_RATE = 5;
    localparam int ST2_STRIPE_FOUR = 3;
    localparam int ST2_STRIPE_ANY = 2;
    localparam int ST2_COPY_PROT = 1;
    localparam int ST2_CAPTURE_RDY = 0;
    // analog input control fields
    localparam int AIC_OUT_SEL_MSB = 7;
    localparam int AIC_PORT_EN = 6;
    localparam int AIC_CLK_SEL = 5;
    localparam int AIC_REF_SEL = 4;
    localparam int AIC_SW_RST_EN = 2;
    localparam int AIC_SIGN_B = 1;
    localparam int AIC_SIGN_A = 0;
    // bits per bus byte
    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef enum logic [3:0] {
        I2C_IDLE, I2C_ADDR, I2C_ACK_ADDR, I2C_SUB, I2C_ACK_SUB,
        I2C_WDATA, I2C_ACK_W, I2C_RDATA, I2C_ACK_R
    } dsr_i2c_e;
endpackage : dsr_pkg

// *** pkg/dsr_raw_if.sv ***
/*
 * raw data gain and offset codes from the register bank to the datapath.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface dsr_raw_if;
    logic [7:0] rawGainCode;
    logic [7:0] rawOffsetCode;
    modport ctrl (output rawGainCode, output rawOffsetCode);
    modport dp (input rawGainCode, input rawOffsetCode);
endinterface : dsr_raw_if

// *** verilog/dsr_raw_datapath.sv ***
/*
 * raw video sample scaler: gain code then offset code, saturated to 8 bits.
 * assumes codes stable from the register bank, one sample per valid cycle.
 */
`timescale 1ns/10ps
module dsr_raw_datapath (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // codes
    dsr_raw_if.dp codes,
    // samples
    input wire logic [7:0] rawIn,
    input wire logic rawInValid,
    output logic [7:0] rawOut,
    output logic rawOutValid
);
    typedef struct packed {
        logic [7:0] data;
        logic valid;
    } dsr_dp_s;

    dsr_dp_s cur_ff;
    dsr_dp_s nxt_dp;
    logic [15:0] product;
    logic [10:0] sum;

    always_comb begin
        product = rawIn * codes.rawGainCode;
        // code 128 passes the sample, 255 about doubles it, 0 cuts it
        sum = {2'b00, product[15:dsr_pkg::RAW_GAIN_SHIFT]}
            + {3'b000, codes.rawOffsetCode}
            - dsr_pkg::RAW_OFFSET_BIAS;
        nxt_dp = cur_ff;
        nxt_dp.valid = rawInValid;
        if (rawInValid) begin
            if (sum[10]) begin
                nxt_dp.data = 8'h00;
            end else if (sum > dsr_pkg::RAW_MAX) begin
                nxt_dp.data = 8'hff;
            end else begin
                nxt_dp.data = sum[7:0];
            end
        end
        if (srst) begin
            nxt_dp = '0;
        end
    end

    always_ff @(posedge clk) begin
        cur_ff <= nxt_dp;
    end

    assign rawOut = cur_ff.data;
    assign rawOutValid = cur_ff.valid;
endmodule : dsr_raw_datapath

// *** verilog/dsr_edge_pulse.sv ***
/*
 * any-edge detector giving a one-cycle pulse while enabled.
 * assumes the input is already synchronous to clk.
 */
`timescale 1ns/10ps
module dsr_edge_pulse (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // control
    input wire logic enable,
    input wire logic level,
    // result
    output logic pulse
);
    typedef struct packed {
        logic prev;
        logic pulse;
    } dsr_edge_s;

    dsr_edge_s cur_ff;
    dsr_edge_s nxt_edge;

    always_comb begin
        nxt_edge.prev = level;
        // both slopes count; ignored entirely when disabled
        nxt_edge.pulse = enable & (level ^ cur_ff.prev);
        if (srst) begin
            nxt_edge = '0;
        end
    end

    always_ff @(posedge clk) begin
        cur_ff <= nxt_edge;
    end

    assign pulse = cur_ff.pulse;
endmodule : dsr_edge_pulse

// *** verilog/dsr_regs_top.sv ***
/*
 * register bank of the decoder: raw gain/offset, two status bytes and the
 * analog input control register, reached by a two-wire serial slave.
 * assumes scl and sda are synchronous to clk and much slower than it;
 * sda is open drain, the wire level is resolved outside.
 */
`timescale 1ns/10ps
// Overview of operation
// - raw data scaled by gain code: 128 nominal, 255 double, 0 off
// - raw data offset code: 0 is -128, 128 is none, 255 is +127
// - first status byte bits 1:0 give detected colour standard
// - first status bit 6 is 1 while horizontal frequency unlocked
// - first status bit 5 is 1 while slow time constant active
// - first status bits 4 and 3 flag gain limited at top, bottom
// - first status bit 2 is 1 while white peak loop active
// - second status bit 7 is 1 for interlaced video
// - second status bit 6 is 0 only when both h and v loops locked
// - second status bit 5 is 0 for 50 Hz, 1 for 60 Hz fields
// - second status flag set when four-line stripe burst detected
// - second status bit 2 set when any stripe burst detected
// - second status capture-ready flag set only when all loops lock
// - control bit 6: converter port 3-state at 0, enabled at 1
// - control bit 5: converters on line-locked clock or external one
// - control bit 4: clamp follows clamp-mode bit, or reference mode
// - control bit 2 enables reset of gain loop on switch input edges
// - control bits 1 and 0 hold static gain sign bits
module dsr_regs_top (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // serial register port
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOeN,
    // raw samples
    input wire logic [7:0] rawIn,
    input wire logic rawInValid,
    output logic [7:0] rawOut,
    output logic rawOutValid,
    // decoder state
    input wire logic horizFreqUnlocked,
    input wire logic vertLoopUnlocked,
    input wire logic otherLoopsUnlocked,
    input wire logic slowTcActive,
    input wire logic gainLimitedTop,
    input wire logic gainLimitedBottom,
    input wire logic whitePeakActive,
    input wire logic [1:0] colourStandardDetected,
    input wire logic interlaceDetected,
    input wire logic fieldRateId,
    input wire logic stripeBurstFourLine,
    input wire logic stripeBurstAny,
    input wire logic copyProtectDetected,
    // analog front end
    input wire logic clampModeBit,
    input wire logic sourceSwitchIndicator,
    output logic converterPortEnable,
    output logic converterClockSelect,
    output logic clampReferenceSelect,
    output logic clampFollowMode,
    output logic gainLoopReset,
    output logic staticGainSignA,
    output logic staticGainSignB,
    output logic analogOutSelMsb
);
    typedef struct packed {
        dsr_pkg::dsr_i2c_e st;
        logic sclPrev;
        logic sdaPrev;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic [7:0] txByte;
        logic [7:0] sub;
        logic isRead;
        logic ackOk;
        logic drvLow;
        logic [7:0] rawGain;
        logic [7:0] rawOffset;
        logic [7:0] aicFive;
        logic [7:0] statusFirst;
        logic [7:0] statusSecond;
    } dsr_top_s;

    dsr_top_s cur_ff;
    dsr_top_s nxt_top;
    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    logic [7:0] readByte;
    logic [7:0] st1;
    logic [7:0] st2;

    dsr_raw_if rawCodes ();

    assign rawCodes.rawGainCode = cur_ff.rawGain;
    assign rawCodes.rawOffsetCode = cur_ff.rawOffset;

    dsr_raw_datapath u_datapath (
        .clk(clk),
        .srst(srst),
        .codes(rawCodes),
        .rawIn(rawIn),
        .rawInValid(rawInValid),
        .rawOut(rawOut),
        .rawOutValid(rawOutValid)
    );

    dsr_edge_pulse u_switch_edge (
        .clk(clk),
        .srst(srst),
        .enable(cur_ff.aicFive[dsr_pkg::AIC_SW_RST_EN]),
        .level(sourceSwitchIndicator),
        .pulse(gainLoopReset)
    );

    // live status snapshot, unused positions forced low
    always_comb begin
        st1 = 8'h00;
        st1[dsr_pkg::ST1_HORIZ_UNLOCK] = horizFreqUnlocked;
        st1[dsr_pkg::ST1_SLOW_TC] = slowTcActive;
        st1[dsr_pkg::ST1_GAIN_TOP] = gainLimitedTop;
        st1[dsr_pkg::ST1_GAIN_BOTTOM] = gainLimitedBottom;
        st1[dsr_pkg::ST1_WHITE_PEAK] = whitePeakActive;
        st1[dsr_pkg::ST1_STD_LSB +: 2] = colourStandardDetected;
        st2 = 8'h00;
        st2[dsr_pkg::ST2_INTERLACE] = interlaceDetected;
        st2[dsr_pkg::ST2_HV_UNLOCK] =
            horizFreqUnlocked | vertLoopUnlocked;
        st2[dsr_pkg::ST2_FIELD_RATE] = fieldRateId;
        st2[dsr_pkg::ST2_STRIPE_FOUR] = stripeBurstFourLine;
        // a four-line burst is one type of stripe burst too
        st2[dsr_pkg::ST2_STRIPE_ANY] =
            stripeBurstAny | stripeBurstFourLine;
        st2[dsr_pkg::ST2_COPY_PROT] = copyProtectDetected;
        st2[dsr_pkg::ST2_CAPTURE_RDY] = ~(horizFreqUnlocked
            | vertLoopUnlocked | otherLoopsUnlocked);
    end

    // byte returned for the current subaddress
    always_comb begin
        unique case (cur_ff.sub)
            dsr_pkg::ADDR_RAW_GAIN: readByte = cur_ff.rawGain;
            dsr_pkg::ADDR_RAW_OFFSET: readByte = cur_ff.rawOffset;
            dsr_pkg::ADDR_STATUS_FIRST: readByte = cur_ff.statusFirst;
            dsr_pkg::ADDR_STATUS_SECOND: readByte = cur_ff.statusSecond;
            dsr_pkg::ADDR_AIC_FIVE: readByte = cur_ff.aicFive;
            default: readByte = 8'h00;
        endcase
    end

    assign sclRise = scl & ~cur_ff.sclPrev;
    assign sclFall = ~scl & cur_ff.sclPrev;
    assign startCond = scl & cur_ff.sclPrev & cur_ff.sdaPrev & ~sdaIn;
    assign stopCond = scl & cur_ff.sclPrev & ~cur_ff.sdaPrev & sdaIn;

    always_comb begin
        nxt_top = cur_ff;
        nxt_top.sclPrev = scl;
        nxt_top.sdaPrev = sdaIn;
        // status sampled every cycle; a read shows the value at byte load
        nxt_top.statusFirst = st1;
        nxt_top.statusSecond = st2;
        if (startCond) begin
            // repeated start is legal in any state
            nxt_top.st = dsr_pkg::I2C_ADDR;
            nxt_top.bitCnt = 4'h0;
            nxt_top.drvLow = 1'b0;
        end else if (stopCond) begin
            nxt_top.st = dsr_pkg::I2C_IDLE;
            nxt_top.drvLow = 1'b0;
        end else begin
            unique case (cur_ff.st)
                dsr_pkg::I2C_IDLE: begin
                    nxt_top.drvLow = 1'b0;
                end
                dsr_pkg::I2C_ADDR,
                dsr_pkg::I2C_SUB,
                dsr_pkg::I2C_WDATA: begin
                    if (sclRise) begin
                        nxt_top.shift = {cur_ff.shift[6:0], sdaIn};
                        nxt_top.bitCnt = cur_ff.bitCnt + 4'h1;
                    end else if (sclFall &&
                            cur_ff.bitCnt == dsr_pkg::BYTE_BITS) begin
                        nxt_top.bitCnt = 4'h0;
                        nxt_top.drvLow = 1'b1;
                        if (cur_ff.st == dsr_pkg::I2C_ADDR) begin
                            if (cur_ff.shift[7:1] == dsr_pkg::DEV_ADDR) begin
                                nxt_top.isRead = cur_ff.shift[0];
                                nxt_top.st = dsr_pkg::I2C_ACK_ADDR;
                            end else begin
                                // other slave addressed: stay silent
                                nxt_top.drvLow = 1'b0;
                                nxt_top.st = dsr_pkg::I2C_IDLE;
                            end
                        end else if (cur_ff.st == dsr_pkg::I2C_SUB) begin
                            nxt_top.sub = cur_ff.shift;
                            nxt_top.st = dsr_pkg::I2C_ACK_SUB;
                        end else begin
                            // status bytes are read only
                            unique case (cur_ff.sub)
                                dsr_pkg::ADDR_RAW_GAIN:
                                    nxt_top.rawGain = cur_ff.shift;
                                dsr_pkg::ADDR_RAW_OFFSET:
                                    nxt_top.rawOffset = cur_ff.shift;
                                dsr_pkg::ADDR_AIC_FIVE:
                                    nxt_top.aicFive = cur_ff.shift
                                        & dsr_pkg::AIC_FIVE_WR_MASK;
                                default: ;
                            endcase
                            nxt_top.sub = cur_ff.sub + 8'h01;
                            nxt_top.st = dsr_pkg::I2C_ACK_W;
                        end
                    end
                end
                dsr_pkg::I2C_ACK_ADDR: begin
                    if (sclFall) begin
                        if (cur_ff.isRead) begin
                            nxt_top.txByte = readByte;
                            nxt_top.drvLow = ~readByte[7];
                            nxt_top.bitCnt = 4'h0;
                            nxt_top.st = dsr_pkg::I2C_RDATA;
                        end else begin
                            nxt_top.drvLow = 1'b0;
                            nxt_top.st = dsr_pkg::I2C_SUB;
                        end
                    end
                end
                dsr_pkg::I2C_ACK_SUB,
                dsr_pkg::I2C_ACK_W: begin
                    if (sclFall) begin
                        nxt_top.drvLow = 1'b0;
                        nxt_top.st = dsr_pkg::I2C_WDATA;
                    end
                end
                dsr_pkg::I2C_RDATA: begin
                    if (sclRise) begin
                        nxt_top.bitCnt = cur_ff.bitCnt + 4'h1;
                    end else if (sclFall) begin
                        if (cur_ff.bitCnt == dsr_pkg::BYTE_BITS) begin
                            // release sda for the host acknowledge
                            nxt_top.drvLow = 1'b0;
                            nxt_top.sub = cur_ff.sub + 8'h01;
                            nxt_top.st = dsr_pkg::I2C_ACK_R;
                        end else begin
                            nxt_top.drvLow = ~cur_ff.txByte[6];
                            nxt_top.txByte = {cur_ff.txByte[6:0], 1'b0};
                        end
                    end
                end
                dsr_pkg::I2C_ACK_R: begin
                    if (sclRise) begin
                        nxt_top.ackOk = ~sdaIn;
                    end else if (sclFall) begin
                        if (cur_ff.ackOk) begin
                            nxt_top.txByte = readByte;
                            nxt_top.drvLow = ~readByte[7];
                            nxt_top.bitCnt = 4'h0;
                            nxt_top.st = dsr_pkg::I2C_RDATA;
                        end else begin
                            nxt_top.st = dsr_pkg::I2C_IDLE;
                        end
                    end
                end
            endcase
        end
        if (srst) begin
            nxt_top = '0;
            nxt_top.st = dsr_pkg::I2C_IDLE;
            nxt_top.rawGain = dsr_pkg::RAW_GAIN_RST;
            nxt_top.rawOffset = dsr_pkg::RAW_OFFSET_RST;
            nxt_top.aicFive = dsr_pkg::AIC_FIVE_RST;
        end
    end

    always_ff @(posedge clk) begin
        cur_ff <= nxt_top;
    end

    // open drain: only ever pulls low
    assign sdaOut = 1'b0;
    assign sdaOeN = ~cur_ff.drvLow;

    assign converterPortEnable =
        cur_ff.aicFive[dsr_pkg::AIC_PORT_EN];
    assign converterClockSelect =
        cur_ff.aicFive[dsr_pkg::AIC_CLK_SEL];
    assign clampReferenceSelect =
        cur_ff.aicFive[dsr_pkg::AIC_REF_SEL];
    // reference mode overrides the clamp-mode bit
    assign clampFollowMode =
        ~cur_ff.aicFive[dsr_pkg::AIC_REF_SEL] & clampModeBit;
    assign staticGainSignA = cur_ff.aicFive[dsr_pkg::AIC_SIGN_A];
    assign staticGainSignB = cur_ff.aicFive[dsr_pkg::AIC_SIGN_B];
    assign analogOutSelMsb = cur_ff.aicFive[dsr_pkg::AIC_OUT_SEL_MSB];
endmodule : dsr_regs_top

// *** tb/dsr_regs_props.sv ***
/* assertions on the ports of the decoder register bank.
   assumes one clock and the synchronous active-high reset. */
`timescale 1ns/10ps
module dsr_regs_props (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // serial port and raw samples
    input wire logic sdaOeN,
    input wire logic rawInValid,
    input wire logic [7:0] rawOut,
    input wire logic rawOutValid,
    // front end
    input wire logic clampModeBit,
    input wire logic sourceSwitchIndicator,
    input wire logic converterPortEnable,
    input wire logic converterClockSelect,
    input wire logic clampReferenceSelect,
    input wire logic clampFollowMode,
    input wire logic gainLoopReset,
    input wire logic staticGainSignA,
    input wire logic staticGainSignB
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    raw_valid_a: assert property (rawInValid |=> rawOutValid)
        else $error("raw sample not answered next cycle");
    raw_idle_a: assert property (
        !rawInValid |=> !rawOutValid && $stable(rawOut))
        else $error("raw output moved without a sample");
    clamp_follow_a: assert property (
        clampFollowMode == (!clampReferenceSelect && clampModeBit))
        else $error("clamp follow mode wrong");
    // the pulse lands one cycle after the input edge; the check accepts one or two
    switch_cause_a: assert property (gainLoopReset |->
        ($past(sourceSwitchIndicator) != $past(sourceSwitchIndicator, 2)) ||
        ($past(sourceSwitchIndicator, 2) != $past(sourceSwitchIndicator, 3)))
        else $error("gain loop reset without switch edge");
    port_en_a: assert property (
        $changed(converterPortEnable) |-> !sdaOeN)
        else $error("port enable moved outside a write");
    clk_sel_a: assert property (
        $changed(converterClockSelect) |-> !sdaOeN)
        else $error("clock select moved outside a write");
    ref_sel_a: assert property (
        $changed(clampReferenceSelect) |-> !sdaOeN)
        else $error("reference select moved outside a write");
    sign_bits_a: assert property (
        $changed({staticGainSignB, staticGainSignA}) |-> !sdaOeN)
        else $error("gain sign bits moved outside a write");
endmodule : dsr_regs_props
bind dsr_regs_top dsr_regs_props dsr_regs_props_i (.clk(clk), .srst(srst),
    .sdaOeN(sdaOeN), .rawInValid(rawInValid), .rawOut(rawOut),
    .rawOutValid(rawOutValid), .clampModeBit(clampModeBit),
    .sourceSwitchIndicator(sourceSwitchIndicator),
    .converterPortEnable(converterPortEnable),
    .converterClockSelect(converterClockSelect),
    .clampReferenceSelect(clampReferenceSelect),
    .clampFollowMode(clampFollowMode), .gainLoopReset(gainLoopReset),
    .staticGainSignA(staticGainSignA), .staticGainSignB(staticGainSignB));

// *** tb/dsr_i2c_host.sv ***
/* two-wire bus host model for the register bank.
   assumes a pull-up on sda: the wire is the and of all drivers. */
`timescale 1ns/10ps
module dsr_i2c_host (
    // clock
    input wire logic clk,
    // bus
    input wire logic sdaWire,
    output logic scl,
    output logic sdaDrv
);
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end
    // 3 clk per level, above the slave's 2 clk minimum
    task hold();
        repeat (3) @(posedge clk);
    endtask : hold
    task bt(input logic b, output logic r);
        sdaDrv <= b;
        hold();
        scl <= 1'b1;
        hold();
        r = sdaWire;
        scl <= 1'b0;
    endtask : bt
    task start();
        sdaDrv <= 1'b1;
        hold();
        scl <= 1'b1;
        hold();
        sdaDrv <= 1'b0;
        hold();
        scl <= 1'b0;
    endtask : start
    task stop();
        sdaDrv <= 1'b0;
        hold();
        scl <= 1'b1;
        hold();
        sdaDrv <= 1'b1;
        hold();
    endtask : stop
    // last is the ninth bit sent: 1 releases for an ack or gives a nack
    task octet(input logic [7:0] d, input logic last,
               output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bt(d[i], r);
            q[i] = r;
        end
        bt(last, r);
        ack = ~r;
    endtask : octet
    task xfer(input logic [6:0] dev, input logic [7:0] sub, d,
              input logic rd, output logic [7:0] q, output logic ok);
        logic [7:0] t;
        logic a0, a1, a2;
        start();
        octet({dev, 1'b0}, 1'b1, t, a0);
        octet(sub, 1'b1, t, a1);
        q = 8'h00;
        if (rd) begin
            start();
            octet({dev, 1'b1}, 1'b1, t, a2);
            octet(8'hff, 1'b1, q, t[0]);
        end else begin
            octet(d, 1'b1, t, a2);
        end
        stop();
        ok = a0 & a1 & a2;
    endtask : xfer
endmodule : dsr_i2c_host

// *** tb/tb_dsr_regs_top.sv ***
/* self-checking bench of the register bank: reset values, status
   reads, control writes, raw scaling and the switch-edge reset.
   assumes the host model and the checker are compiled before it. */
`timescale 1ns/10ps
module tb_dsr_regs_top;
    logic clk, srst, scl, sdaDrv, sdaOut, sdaOeN, sdaW, swInd;
    logic [7:0] rawIn, rawOut;
    logic rawInValid, rawOutValid;
    logic [14:0] dec;
    logic portEn, clkSel, refSel, followMode, loopRst, signA, signB, selMsb;
    int errCount = 0;
    int nTests = 0;
    // gain/offset: nominal, double, off, offset at both ends
    logic [15:0] tab [5] = '{16'h8080, 16'hff80, 16'h0080, 16'h8000,
                             16'h80ff};
    assign sdaW = sdaDrv & (sdaOeN | sdaOut);
    dsr_i2c_host dsr_i2c_host_i (.clk(clk), .sdaWire(sdaW), .scl(scl),
        .sdaDrv(sdaDrv));
    dsr_regs_top dsr_regs_top_i (.clk(clk), .srst(srst), .scl(scl),
        .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .rawIn(rawIn),
        .rawInValid(rawInValid), .rawOut(rawOut), .rawOutValid(rawOutValid),
        .horizFreqUnlocked(dec[0]), .vertLoopUnlocked(dec[1]),
        .otherLoopsUnlocked(dec[2]), .slowTcActive(dec[3]),
        .gainLimitedTop(dec[4]), .gainLimitedBottom(dec[5]),
        .whitePeakActive(dec[6]), .colourStandardDetected(dec[8:7]),
        .interlaceDetected(dec[9]), .fieldRateId(dec[10]),
        .stripeBurstFourLine(dec[11]), .stripeBurstAny(dec[12]),
        .copyProtectDetected(dec[13]), .clampModeBit(dec[14]),
        .sourceSwitchIndicator(swInd), .converterPortEnable(portEn),
        .converterClockSelect(clkSel), .clampReferenceSelect(refSel),
        .clampFollowMode(followMode), .gainLoopReset(loopRst),
        .staticGainSignA(signA), .staticGainSignB(signB),
        .analogOutSelMsb(selMsb));
    function automatic logic [7:0] st1(input logic [14:0] s);
        return {1'b0, s[0], s[3], s[4], s[5], s[6], s[8:7]};
    endfunction : st1
    function automatic logic [7:0] st2(input logic [14:0] s);
        return {s[9], s[0] | s[1], s[10], 1'b0, s[11], s[11] | s[12],
                s[13], ~|s[2:0]};
    endfunction : st2
    function automatic logic [7:0] scale(input logic [7:0] x, g, o);
        int v;
        v = ((int'(x) * int'(g)) >>> 7) + int'(o) - 128;
        return v < 0 ? 8'h00 : v > 255 ? 8'hff : 8'(v);
    endfunction : scale
    task chk(input logic [7:0] got, exp);
        nTests++;
        if (got !== exp) begin
            errCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, d);
        logic [7:0] q;
        logic ok;
        dsr_i2c_host_i.xfer(dsr_pkg::DEV_ADDR, a, d, 1'b0, q, ok);
        chk({7'h0, ok}, 8'h01);
    endtask : wr
    task rdChk(input logic [7:0] a, e);
        logic [7:0] q;
        logic ok;
        dsr_i2c_host_i.xfer(dsr_pkg::DEV_ADDR, a, 8'h00, 1'b1, q, ok);
        chk({7'h0, ok}, 8'h01);
        chk(q, e);
    endtask : rdChk
    task testDone();
        if (errCount == 0 && nTests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : testDone
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (60000) @(posedge clk);
        $display("wrong value at %0t: watchdog expired", $time);
        errCount++;
        testDone();
    end
    initial begin
        logic [7:0] q, v, g, o, x, pX, sub1, sub2;
        logic [14:0] s;
        logic ok, pV, vb;
        int n;
        srst = 1'b1;
        rawIn = 8'h00;
        rawInValid = 1'b0;
        dec = 15'h0;
        swInd = 1'b0;
        void'($urandom(32'h51874f8d));
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        rdChk(dsr_pkg::ADDR_RAW_GAIN, 8'h80);
        rdChk(dsr_pkg::ADDR_RAW_OFFSET, 8'h80);
        rdChk(dsr_pkg::ADDR_AIC_FIVE, 8'h00);
        rdChk(8'h20, 8'h00);
        // status bytes: zeros, ones, then random with every standard
        sub1 = dsr_pkg::ADDR_STATUS_FIRST;
        sub2 = dsr_pkg::ADDR_STATUS_SECOND;
        for (int i = 0; i < 8; i++) begin
            s = i == 0 ? 15'h0 : i == 1 ? 15'h7fff : 15'($urandom);
            s[8:7] = i[1:0];
            @(posedge clk);
            dec <= s;
            wr(dsr_pkg::ADDR_STATUS_FIRST, ~st1(s));
            rdChk(sub1, st1(s));
            rdChk(sub2, st2(s));
        end
        for (int i = 0; i < 6; i++) begin
            v = i == 0 ? 8'hff : i == 1 ? 8'h00 : 8'($urandom);
            @(posedge clk);
            dec <= 15'($urandom);
            wr(dsr_pkg::ADDR_AIC_FIVE, v);
            rdChk(dsr_pkg::ADDR_AIC_FIVE, v & 8'hf7);
            chk({selMsb, portEn, clkSel, refSel, 2'h0, signB, signA},
                v & 8'hf3);
            chk({7'h0, followMode}, {7'h0, ~v[4] & dec[14]});
        end
        // a foreign slave address must be neither acked nor stored
        dsr_i2c_host_i.xfer(dsr_pkg::DEV_ADDR ^ 7'h01,
            dsr_pkg::ADDR_RAW_GAIN, 8'h12, 1'b0, q, ok);
        chk({7'h0, ok}, 8'h00);
        rdChk(dsr_pkg::ADDR_RAW_GAIN, 8'h80);
        for (int k = 0; k < 6; k++) begin
            {g, o} = k < 5 ? tab[k] : 16'($urandom);
            wr(dsr_pkg::ADDR_RAW_GAIN, g);
            wr(dsr_pkg::ADDR_RAW_OFFSET, o);
            rdChk(dsr_pkg::ADDR_RAW_GAIN, g);
            pV = 1'b0;
            pX = 8'h00;
            repeat (24) begin
                @(posedge clk);
                x = 8'($urandom);
                vb = 1'($urandom);
                rawIn <= x;
                rawInValid <= vb;
                #1;
                if (pV) chk(rawOut, scale(pX, g, o));
                chk({7'h0, rawOutValid}, {7'h0, pV});
                pX = x;
                pV = vb;
            end
            @(posedge clk);
            rawInValid <= 1'b0;
        end
        // both input edges, with the reset input disabled and enabled
        for (int k = 0; k < 4; k++) begin
            wr(dsr_pkg::ADDR_AIC_FIVE, {5'h0, k[1], 2'h0});
            n = 0;
            @(posedge clk);
            swInd <= ~swInd;
            repeat (4) begin
                @(posedge clk);
                #1;
                n += int'(loopRst === 1'b1);
            end
            chk(8'(n), {7'h0, k[1]});
        end
        testDone();
    end
endmodule : tb_dsr_regs_top
